// >>> logic/fcg_pkg.sv
// Package with constants and types for the flash command guard block
`default_nettype none
package fcg_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_CLKDIV = 8'h00;
  localparam logic [7:0] OFS_SECURE = 8'h01;
  localparam logic [7:0] OFS_CONFIG = 8'h02;
  localparam logic [7:0] OFS_PROT   = 8'h03;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h05;
  // Status and config bit positions
  localparam int BIT_CMD_BUFFER_EMPTY_FLAG  = 7;
  localparam int BIT_CMD_COMPLETE_FLAG   = 6;
  localparam int BIT_PROTECT_VIOLATION_FLAG  = 5;
  localparam int BIT_ACCESS_ERROR_FLAG = 4;
  localparam int BIT_BUFFER_EMPTY_IRQ_ENABLE  = 7;
  localparam int BIT_COMPLETE_IRQ_ENABLE   = 6;
  localparam int BIT_KEY_ACCESS_BIT = 5;
  // Protection bits that must all be set for no protection
  localparam int BIT_POPEN  = 7;
  localparam int BIT_PHDIS  = 5;
  localparam int BIT_PLDIS  = 2;
  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] INVALID_RD = 16'hFFFF;
  // Command codes
  localparam logic [7:0] CMD_VERIFY = 8'h05;
  localparam logic [7:0] CMD_PROG   = 8'h20;
  localparam logic [7:0] CMD_SERASE = 8'h40;
  localparam logic [7:0] CMD_MERASE = 8'h41;
  // Configuration field and key addresses
  localparam logic [15:0] KEY_BASE  = 16'hFF00;
  localparam logic [15:0] KEY_LAST  = 16'hFF07;
  localparam logic [15:0] PROT_ADDR = 16'hFF0D;
  localparam logic [15:0] SEC_ADDR  = 16'hFF0F;
  localparam logic [15:0] KEY_ZERO  = 16'h0000;
  localparam logic [15:0] KEY_ONES  = 16'hFFFF;
  localparam logic [1:0]  SEC_OPEN  = 2'b10;
  localparam logic [1:0]  BACKDOOR_ENABLE_FIELD_ON  = 2'b10;
  localparam logic [2:0]  LOAD_LAST = 3'h5;
  // State types
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fcg_seq_t;
  typedef enum logic [2:0] {KEY_IDLE, KEY_RUN, KEY_DONE, KEY_LOCK, KEY_OPEN} fcg_key_t;
endpackage
`default_nettype wire

// >>> logic/fcg_guard.sv
// Flash command guard: sequence checks, locking, modes, security and interrupt
`default_nettype none
module fcg_guard (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        arr_wr,
  input  wire logic        arr_byte,
  input  wire logic [15:0] arr_addr,
  input  wire logic [15:0] arr_wdata,
  input  wire logic        arr_rd,
  input  wire logic [15:0] arr_data_in,
  output logic      [15:0] arr_rdata,
  input  wire logic        addr_protected,
  input  wire logic        nonsec_src,
  input  wire logic        background_debug_mode,
  input  wire logic        special_single_chip,
  input  wire logic        wait_mode,
  input  wire logic        stop_mode,
  output logic             eng_start,
  output logic             eng_abort,
  output logic      [7:0]  eng_cmd,
  output logic      [15:0] eng_addr,
  output logic      [15:0] eng_data,
  input  wire logic        eng_done,
  output logic             cfg_rd,
  output logic      [15:0] cfg_addr,
  input  wire logic [15:0] cfg_rdata,
  output logic             cpu_hold,
  output logic             secured,
  output logic             irq,
  output logic             wake_req
);
  logic             rst_s1_q, rst_n;
  logic [7:0]       div_q, cfg_q, prot_q, sec_q, cmd_q;
  logic             div_set_q, access_error_flag_q, protect_violation_flag_q, cmd_complete_flag_q, active_q, pend_q;
  logic             stop_q, adr_prot_q;
  logic [15:0]      buf_addr_q, buf_data_q;
  logic [15:0]      key_q [4];
  logic [2:0]       ld_cnt_q, ld_idx_q;
  logic             ld_busy_q, ld_vld_q;
  logic [1:0]       kcnt_q;
  fcg_pkg::fcg_seq_t seq_q, seq_d;
  fcg_pkg::fcg_key_t key_st_q, key_st_d;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // Register write decode
  wire wr_div  = reg_wr && (reg_addr == fcg_pkg::OFS_CLKDIV);
  wire wr_cfg  = reg_wr && (reg_addr == fcg_pkg::OFS_CONFIG);
  wire wr_prot = reg_wr && (reg_addr == fcg_pkg::OFS_PROT);
  wire wr_stat = reg_wr && (reg_addr == fcg_pkg::OFS_STATUS);
  wire wr_cmd  = reg_wr && (reg_addr == fcg_pkg::OFS_CMD);
  wire cmd_buffer_empty_flag   = !pend_q;
  wire key_access_bit  = cfg_q[fcg_pkg::BIT_KEY_ACCESS_BIT];

  // Security and key access qualification
  wire sec_open   = (sec_q[1:0] == fcg_pkg::SEC_OPEN) || (key_st_q == fcg_pkg::KEY_OPEN);
  wire backdoor_enable_field_ok   = (sec_q[7:6] == fcg_pkg::BACKDOOR_ENABLE_FIELD_ON);
  wire bdm_ssc    = background_debug_mode && special_single_chip;
  wire key_en     = backdoor_enable_field_ok && key_access_bit && !bdm_ssc;
  wire key_range  = (arr_addr >= fcg_pkg::KEY_BASE) && (arr_addr <= fcg_pkg::KEY_LAST);
  wire key_wr     = arr_wr && key_en && key_range;
  wire cmd_arr_wr = arr_wr && !key_wr;
  wire key_access_bit_off = wr_cfg && !reg_wdata[fcg_pkg::BIT_KEY_ACCESS_BIT] && key_access_bit;
  wire [15:0] key_exp_addr = fcg_pkg::KEY_BASE + {13'h0000, kcnt_q, 1'b0};
  wire key_ok = (arr_addr == key_exp_addr) && !arr_byte
             && (arr_wdata == key_q[kcnt_q])
             && (arr_wdata != fcg_pkg::KEY_ZERO) && (arr_wdata != fcg_pkg::KEY_ONES);

  // Command checks
  wire code_valid = (reg_wdata == fcg_pkg::CMD_VERIFY) || (reg_wdata == fcg_pkg::CMD_PROG)
                 || (reg_wdata == fcg_pkg::CMD_SERASE) || (reg_wdata == fcg_pkg::CMD_MERASE);
  wire is_mass    = (reg_wdata == fcg_pkg::CMD_MERASE);
  wire is_target  = (reg_wdata == fcg_pkg::CMD_PROG) || (reg_wdata == fcg_pkg::CMD_SERASE);
  wire any_prot   = !(prot_q[fcg_pkg::BIT_POPEN] && prot_q[fcg_pkg::BIT_PHDIS]
                      && prot_q[fcg_pkg::BIT_PLDIS]);
  wire sec_block  = !sec_open && !is_mass && (nonsec_src || background_debug_mode);

  // Illegal operations that raise the access error
  wire arr_bad = cmd_arr_wr && (!div_set_q || !cmd_buffer_empty_flag
               || arr_byte || arr_addr[0]
               || (seq_q != fcg_pkg::SEQ_IDLE));
  wire reg_bad_a = (seq_q == fcg_pkg::SEQ_ADDR) && reg_wr && !wr_cmd;
  wire reg_bad_c = (seq_q == fcg_pkg::SEQ_CMD) && reg_wr
                && !(wr_stat && reg_wdata[fcg_pkg::BIT_CMD_BUFFER_EMPTY_FLAG]);
  wire cmd_idle  = wr_cmd && (seq_q == fcg_pkg::SEQ_IDLE);
  wire cmd_bad   = wr_cmd && (seq_q == fcg_pkg::SEQ_ADDR)
                && (!code_valid || sec_block);
  wire pv_set    = wr_cmd && (seq_q == fcg_pkg::SEQ_ADDR) && code_valid && !sec_block
                && ((is_target && adr_prot_q) || (is_mass && any_prot));
  wire stop_in   = stop_mode && !stop_q;
  wire stop_out  = !stop_mode && stop_q;
  wire stop_kill = stop_in && !cmd_complete_flag_q;
  wire acc_set   = arr_bad || reg_bad_a || reg_bad_c || cmd_idle || cmd_bad || stop_kill;
  wire locked    = access_error_flag_q || protect_violation_flag_q;
  wire launch    = wr_stat && reg_wdata[fcg_pkg::BIT_CMD_BUFFER_EMPTY_FLAG]
                && (seq_q == fcg_pkg::SEQ_CMD) && !locked;
  wire start_pend = pend_q && active_q && eng_done && !stop_kill;

  // Engine strobes
  assign eng_start = (launch && (!active_q || eng_done)) || start_pend;
  assign eng_abort = !rst_n || stop_kill;
  assign eng_cmd   = cmd_q;
  assign eng_addr  = buf_addr_q;
  assign eng_data  = buf_data_q;

  // Command write sequence tracking
  always_comb begin
    seq_d = seq_q;
    case (seq_q)
      fcg_pkg::SEQ_IDLE: if (cmd_arr_wr && !arr_bad && !locked) seq_d = fcg_pkg::SEQ_ADDR;
      fcg_pkg::SEQ_ADDR: if (wr_cmd && !cmd_bad && !pv_set) seq_d = fcg_pkg::SEQ_CMD;
      fcg_pkg::SEQ_CMD:  if (wr_stat) seq_d = fcg_pkg::SEQ_IDLE;
      default:           seq_d = fcg_pkg::SEQ_IDLE;
    endcase
    if (acc_set || pv_set) seq_d = fcg_pkg::SEQ_IDLE;
  end

  // Sequence state and staged buffers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_q      <= fcg_pkg::SEQ_IDLE;
      buf_addr_q <= fcg_pkg::RST_WORD;
      buf_data_q <= fcg_pkg::RST_WORD;
      cmd_q      <= fcg_pkg::RST_BYTE;
      adr_prot_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
      if (seq_q == fcg_pkg::SEQ_IDLE && seq_d == fcg_pkg::SEQ_ADDR) begin
        buf_addr_q <= arr_addr;
        buf_data_q <= arr_wdata;
        adr_prot_q <= addr_protected;
      end
      if (seq_q == fcg_pkg::SEQ_ADDR && seq_d == fcg_pkg::SEQ_CMD) cmd_q <= reg_wdata;
    end
  end

  // Two-stage pipeline and flags; hardware set wins over software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      pend_q   <= 1'b0;
      cmd_complete_flag_q   <= 1'b1;
      access_error_flag_q <= 1'b0;
      protect_violation_flag_q  <= 1'b0;
      stop_q   <= 1'b0;
    end else begin
      stop_q <= stop_mode;
      if (stop_kill) begin
        active_q <= 1'b0;
        pend_q   <= 1'b0;
        cmd_complete_flag_q   <= 1'b1;
      end else begin
        if (eng_start) active_q <= 1'b1;
        else if (eng_done) active_q <= 1'b0;
        if (launch && active_q && !eng_done) pend_q <= 1'b1;
        else if (start_pend || stop_out) pend_q <= 1'b0;
        if (launch) cmd_complete_flag_q <= 1'b0;
        else if (eng_done && !pend_q) cmd_complete_flag_q <= 1'b1;
      end
      if (acc_set) access_error_flag_q <= 1'b1;
      else if (wr_stat && reg_wdata[fcg_pkg::BIT_ACCESS_ERROR_FLAG]) access_error_flag_q <= 1'b0;
      if (pv_set) protect_violation_flag_q <= 1'b1;
      else if (wr_stat && reg_wdata[fcg_pkg::BIT_PROTECT_VIOLATION_FLAG]) protect_violation_flag_q <= 1'b0;
    end
  end

  // Software registers; protection only writable in debug mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= fcg_pkg::RST_BYTE;
      div_set_q <= 1'b0;
      cfg_q     <= fcg_pkg::RST_BYTE;
    end else begin
      if (wr_div && !reg_bad_a && !reg_bad_c) begin
        div_q     <= reg_wdata;
        div_set_q <= 1'b1;
      end
      if (wr_cfg && !reg_bad_a && !reg_bad_c) cfg_q <= reg_wdata;
    end
  end

  // Configuration load after reset; processor held meanwhile
  assign cfg_rd   = ld_busy_q && (ld_cnt_q <= fcg_pkg::LOAD_LAST);
  assign cfg_addr = (ld_cnt_q == 3'h4) ? fcg_pkg::PROT_ADDR
                  : (ld_cnt_q == 3'h5) ? fcg_pkg::SEC_ADDR
                  : fcg_pkg::KEY_BASE + {12'h000, ld_cnt_q[1:0], 2'b00} / 16'h0002;
  assign cpu_hold = ld_busy_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_busy_q <= 1'b1;
      ld_cnt_q  <= 3'h0;
      ld_vld_q  <= 1'b0;
      ld_idx_q  <= 3'h0;
      prot_q    <= fcg_pkg::RST_BYTE;
      sec_q     <= fcg_pkg::RST_BYTE;
      for (int i = 0; i < 4; i++) key_q[i] <= fcg_pkg::RST_WORD;
    end else begin
      ld_vld_q <= cfg_rd;
      ld_idx_q <= ld_cnt_q;
      if (cfg_rd) ld_cnt_q <= ld_cnt_q + 3'h1;
      if (ld_vld_q) begin
        if (ld_idx_q == 3'h4) prot_q <= cfg_rdata[7:0];
        else if (ld_idx_q == fcg_pkg::LOAD_LAST) sec_q <= cfg_rdata[7:0];
        else key_q[ld_idx_q[1:0]] <= cfg_rdata;
        if (ld_idx_q == fcg_pkg::LOAD_LAST) ld_busy_q <= 1'b0;
      end
      if (wr_prot && background_debug_mode && !ld_busy_q) prot_q <= reg_wdata;
    end
  end

  // Backdoor key state machine; lock held until reset
  always_comb begin
    key_st_d = key_st_q;
    case (key_st_q)
      fcg_pkg::KEY_IDLE, fcg_pkg::KEY_RUN: begin
        if (key_wr) key_st_d = !key_ok ? fcg_pkg::KEY_LOCK
                             : (kcnt_q == 2'h3) ? fcg_pkg::KEY_DONE
                             : fcg_pkg::KEY_RUN;
        else if (key_access_bit_off && key_st_q == fcg_pkg::KEY_RUN) key_st_d = fcg_pkg::KEY_LOCK;
      end
      fcg_pkg::KEY_DONE: begin
        if (key_wr) key_st_d = fcg_pkg::KEY_LOCK;
        else if (key_access_bit_off) key_st_d = fcg_pkg::KEY_OPEN;
      end
      fcg_pkg::KEY_LOCK: key_st_d = fcg_pkg::KEY_LOCK;
      fcg_pkg::KEY_OPEN: key_st_d = fcg_pkg::KEY_OPEN;
      default:           key_st_d = fcg_pkg::KEY_LOCK;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_st_q <= fcg_pkg::KEY_IDLE;
      kcnt_q   <= 2'h0;
    end else begin
      key_st_q <= key_st_d;
      if (key_wr) kcnt_q <= kcnt_q + 2'h1;
    end
  end

  // Read data, one cycle after the strobe; busy or key access reads invalid
  wire [7:0] stat_rd = {cmd_buffer_empty_flag, cmd_complete_flag_q, protect_violation_flag_q, access_error_flag_q, 4'h0};
  wire [7:0] sec_rd  = sec_open ? {sec_q[7:2], fcg_pkg::SEC_OPEN} : sec_q;
  wire [7:0] rd_mux  = (reg_addr == fcg_pkg::OFS_CLKDIV) ? div_q
                     : (reg_addr == fcg_pkg::OFS_SECURE) ? sec_rd
                     : (reg_addr == fcg_pkg::OFS_CONFIG) ? cfg_q
                     : (reg_addr == fcg_pkg::OFS_PROT)   ? prot_q
                     : (reg_addr == fcg_pkg::OFS_STATUS) ? stat_rd
                     : (reg_addr == fcg_pkg::OFS_CMD)    ? cmd_q
                     : fcg_pkg::RST_BYTE;
  wire arr_invalid = key_access_bit || !cmd_complete_flag_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= fcg_pkg::RST_BYTE;
      arr_rdata <= fcg_pkg::RST_WORD;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : fcg_pkg::RST_BYTE;
      if (arr_rd) arr_rdata <= arr_invalid ? fcg_pkg::INVALID_RD : arr_data_in;
    end
  end

  // Interrupt level, security state, wake request
  assign irq = (cmd_buffer_empty_flag && cfg_q[fcg_pkg::BIT_BUFFER_EMPTY_IRQ_ENABLE])
            || (cmd_complete_flag_q && cfg_q[fcg_pkg::BIT_COMPLETE_IRQ_ENABLE]);
  assign wake_req = wait_mode && irq;
  assign secured  = !sec_open;

  // Checks
  misalign_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arr_wr && !key_wr && (arr_byte || arr_addr[0])) |=> access_error_flag_q && seq_q == fcg_pkg::SEQ_IDLE)
    else $error("misaligned array write not flagged");
  nodiv_err_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arr_wr && !key_wr && !div_set_q) |=> access_error_flag_q)
    else $error("array write before divider setup not flagged");
  bad_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_cmd && seq_q == fcg_pkg::SEQ_ADDR && !code_valid) |=> access_error_flag_q && !cmd_complete_flag_q == $past(!cmd_complete_flag_q))
    else $error("invalid command not flagged");
  lock_launch_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (access_error_flag_q || protect_violation_flag_q) && !active_q && !pend_q |-> !eng_start)
    else $error("command launched while locked");
  read_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && !reg_wr && !arr_wr && !stop_mode && !$past(stop_mode) && !access_error_flag_q)
      |=> !access_error_flag_q)
    else $error("register read raised access error");
  stop_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (stop_mode && !$past(stop_mode) && !cmd_complete_flag_q) |-> eng_abort ##1 (cmd_complete_flag_q && access_error_flag_q))
    else $error("stop entry did not abort command");
  irq_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cmd_complete_flag_q && cfg_q[fcg_pkg::BIT_COMPLETE_IRQ_ENABLE]) [*2] |-> irq)
    else $error("interrupt dropped while enabled flag set");
  key_lock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    key_st_q == fcg_pkg::KEY_LOCK |=> key_st_q == fcg_pkg::KEY_LOCK && !$past(sec_open) == secured)
    else $error("key lock released without reset");
  hold_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(rst_n) |-> cpu_hold [*7])
    else $error("processor released before configuration loaded");
  key_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (arr_rd && key_access_bit) |=> arr_rdata == fcg_pkg::INVALID_RD)
    else $error("array read during key access returned data");
  cv_launch: cover property (@(posedge ref_clk) disable iff (!rst_n) launch && !active_q);
  cv_buffer: cover property (@(posedge ref_clk) disable iff (!rst_n) start_pend);
  cv_unsec:  cover property (@(posedge ref_clk) disable iff (!rst_n)
    key_st_q == fcg_pkg::KEY_DONE ##1 key_st_q == fcg_pkg::KEY_OPEN);
  cv_stop:   cover property (@(posedge ref_clk) disable iff (!rst_n) stop_kill);
endmodule
`default_nettype wire

// >>> verif/fcg_engine_model.sv
// Behavioural flash array and algorithm engine facing the command guard
`default_nettype none
module fcg_engine_model #(
  parameter int          DONE_DLY  = 20,
  parameter logic [63:0] KEY_WORDS = 64'h1234_5678_9ABC_DEF1,
  parameter logic [7:0]  SEC_BYTE  = 8'h80,
  parameter logic [7:0]  PROT_BYTE = 8'hFF
) (
  input  wire logic        ref_clk,
  input  wire logic        eng_start,
  input  wire logic        eng_abort,
  output logic             eng_done,
  input  wire logic        cfg_rd,
  input  wire logic [15:0] cfg_addr,
  output logic      [15:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q = 0;
  initial eng_done = 1'b0;
  initial cfg_rdata = 16'h0000;
  // Config field answers one cycle after a read, otherwise toggles every cycle
  always @(posedge ref_clk) begin
    if (cfg_rd === 1'b1) begin
      case (cfg_addr)
        16'hFF00: cfg_rdata <= KEY_WORDS[63:48];
        16'hFF02: cfg_rdata <= KEY_WORDS[47:32];
        16'hFF04: cfg_rdata <= KEY_WORDS[31:16];
        16'hFF06: cfg_rdata <= KEY_WORDS[15:0];
        16'hFF0D: cfg_rdata <= {8'h00, PROT_BYTE};
        16'hFF0F: cfg_rdata <= {8'h00, SEC_BYTE};
        default:  cfg_rdata <= 16'h0000;
      endcase
    end else begin
      cfg_rdata <= ~cfg_rdata;
    end
  end
  // Algorithm runs for DONE_DLY cycles; an abort drops it at once
  always @(posedge ref_clk) begin
    eng_done <= (eng_abort !== 1'b1) && (eng_start !== 1'b1) && (cnt_q == 1);
    if (eng_abort === 1'b1) begin
      cnt_q <= 0;
    end else if (eng_start === 1'b1) begin
      cnt_q <= DONE_DLY;
    end else if (cnt_q > 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
endmodule
`default_nettype wire

// >>> verif/flash_cmd_guard_security_bench.sv
// Self-checking bench for the flash command guard
`default_nettype none
module flash_cmd_guard_security_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, arr_wr = 1'b0;
  logic        arr_byte = 1'b0, arr_rd = 1'b0, addr_protected = 1'b0, nonsec_src = 1'b0;
  logic        background_debug_mode = 1'b0, wait_mode = 1'b0, stop_mode = 1'b0, st = 1'b0, ssc = 1'b0;
  logic        eng_start, eng_abort, eng_done, cfg_rd, cpu_hold, secured, irq, wake_req;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, eng_cmd;
  logic [15:0] arr_addr = 16'h0000, arr_wdata = 16'h0000;
  logic [15:0] arr_rdata, eng_addr, eng_data, cfg_addr, cfg_rdata;
  logic [63:0] keys = 64'h1234_5678_9ABC_DEF1;
  int          errors = 0, n_compared = 0, n_starts = 0, cycles = 0;

  fcg_guard fcg_guard_i (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .arr_wr(arr_wr), .arr_byte(arr_byte), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_rd(arr_rd), .arr_data_in(16'h5A5A), .arr_rdata(arr_rdata),
    .addr_protected(addr_protected), .nonsec_src(nonsec_src), .background_debug_mode(background_debug_mode),
    .special_single_chip(ssc), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .eng_start(eng_start), .eng_abort(eng_abort), .eng_cmd(eng_cmd), .eng_addr(eng_addr),
    .eng_data(eng_data), .eng_done(eng_done), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata), .cpu_hold(cpu_hold), .secured(secured), .irq(irq),
    .wake_req(wake_req));
  fcg_engine_model fcg_engine_model_i (.ref_clk(ref_clk), .eng_start(eng_start),
    .eng_abort(eng_abort), .eng_done(eng_done), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_rdata(cfg_rdata));

  // Clock, launch counter and run limit
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (eng_start === 1'b1) n_starts++;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write; st keeps the launch strobe seen during the write cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    #1 st = eng_start;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask
  task automatic awr(input logic [15:0] a, input logic [15:0] d, input logic b, input logic p);
    @(posedge ref_clk);
    arr_wr <= 1'b1;
    arr_byte <= b;
    arr_addr <= a;
    arr_wdata <= d;
    addr_protected <= p;
    @(posedge ref_clk);
    arr_wr <= 1'b0;
  endtask
  task automatic ard(input logic [15:0] exp);
    @(posedge ref_clk);
    arr_rd <= 1'b1;
    @(posedge ref_clk);
    arr_rd <= 1'b0;
    #1 chk(arr_rdata, exp);
  endtask
  task automatic seq(input logic [15:0] a, input logic [15:0] d, input logic [7:0] c,
                     input logic p);
    awr(a, d, 1'b0, p);
    wr(fcg_pkg::OFS_CMD, c);
    wr(fcg_pkg::OFS_STATUS, 8'h80);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 100 && eng_done !== 1'b1; i++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1 chk(16'(eng_abort), 16'h0001);
    chk(16'(cpu_hold), 16'h0001);
    chk(16'(secured), 16'h0001);
    @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 50 && cpu_hold !== 1'b0; i++) @(posedge ref_clk);
    chk(16'(cpu_hold), 16'h0000);
  endtask

  // Launch of every valid code, interrupt levels, buffering in wait mode
  task automatic t_prog();
    logic [7:0] codes [4];
    int         k;
    codes = '{fcg_pkg::CMD_VERIFY, fcg_pkg::CMD_PROG, fcg_pkg::CMD_SERASE, fcg_pkg::CMD_MERASE};
    do_reset();
    rd(fcg_pkg::OFS_SECURE, 8'h80);
    awr(16'h8000, 16'h1111, 1'b0, 1'b0);
    rd(fcg_pkg::OFS_STATUS, 8'hD0);
    wr(fcg_pkg::OFS_STATUS, 8'h10);
    rd(fcg_pkg::OFS_STATUS, 8'hC0);
    wr(fcg_pkg::OFS_CLKDIV, 8'h0A);
    wr(fcg_pkg::OFS_CONFIG, 8'h80);
    #1 chk(16'(irq), 16'h0001);
    wr(fcg_pkg::OFS_CONFIG, 8'h40);
    for (int i = 0; i < 4; i++) begin
      seq(16'h8000 + 16'(2 * i), 16'h0100 + 16'(i), codes[i], 1'b0);
      #1 chk(16'(st), 16'h0001);
      chk(16'(eng_cmd), 16'(codes[i]));
      chk(eng_addr, 16'h8000 + 16'(2 * i));
      chk(eng_data, 16'h0100 + 16'(i));
      chk(16'(irq), 16'h0000);
      ard(16'hFFFF);
      wait_done();
      chk(16'(irq), 16'h0001);
    end
    ard(16'h5A5A);
    k = n_starts;
    seq(16'h8010, 16'h0AAA, fcg_pkg::CMD_PROG, 1'b0);
    wait_mode <= 1'b1;
    seq(16'h8012, 16'h0BBB, fcg_pkg::CMD_PROG, 1'b0);
    chk(16'(st), 16'h0000);
    rd(fcg_pkg::OFS_STATUS, 8'h00);
    wait_done();
    wait_done();
    chk(16'(n_starts - k), 16'h0002);
    chk(16'(wake_req), 16'h0001);
    wr(fcg_pkg::OFS_CONFIG, 8'h00);
    wait_mode <= 1'b0;
    $display("test prog done");
  endtask

  // Each illegal step sets the access error and locks further launches
  task automatic t_errors();
    int k;
    awr(16'h8000, 16'h2222, 1'b0, 1'b0);
    rd(fcg_pkg::OFS_STATUS, 8'hC0);
    wr(fcg_pkg::OFS_CMD, fcg_pkg::CMD_PROG);
    wr(fcg_pkg::OFS_STATUS, 8'h80);
    wait_done();
    for (int i = 0; i < 8; i++) begin
      awr(16'h8000 + 16'(i == 0), 16'h2222, i == 1, 1'b0);
      case (i)
        2: wr(fcg_pkg::OFS_CMD, 8'h33);
        3: awr(16'h8002, 16'h2222, 1'b0, 1'b0);
        4: wr(fcg_pkg::OFS_CLKDIV, 8'h0A);
        5: begin
          wr(fcg_pkg::OFS_CMD, fcg_pkg::CMD_PROG);
          wr(fcg_pkg::OFS_CMD, fcg_pkg::CMD_PROG);
        end
        6: begin
          wr(fcg_pkg::OFS_CMD, fcg_pkg::CMD_PROG);
          wr(fcg_pkg::OFS_CONFIG, 8'h00);
        end
        7: begin
          wr(fcg_pkg::OFS_CMD, fcg_pkg::CMD_PROG);
          wr(fcg_pkg::OFS_STATUS, 8'h00);
        end
        default: ;
      endcase
      rd(fcg_pkg::OFS_STATUS, 8'hD0);
      k = n_starts;
      seq(16'h8000, 16'h2222, fcg_pkg::CMD_PROG, 1'b0);
      chk(16'(n_starts), 16'(k));
      wr(fcg_pkg::OFS_STATUS, 8'h10);
      rd(fcg_pkg::OFS_STATUS, 8'hC0);
    end
    $display("test errors done");
  endtask

  // Protected targets, guarded mass erase, protection writes in debug mode
  task automatic t_protect();
    seq(16'h8000, 16'h3333, fcg_pkg::CMD_PROG, 1'b1);
    chk(16'(st), 16'h0000);
    rd(fcg_pkg::OFS_STATUS, 8'hE0);
    seq(16'h8000, 16'h3333, fcg_pkg::CMD_PROG, 1'b0);
    chk(16'(st), 16'h0000);
    rd(fcg_pkg::OFS_STATUS, 8'hF0);
    wr(fcg_pkg::OFS_STATUS, 8'h30);
    wr(fcg_pkg::OFS_PROT, 8'h00);
    rd(fcg_pkg::OFS_PROT, 8'hFF);
    background_debug_mode <= 1'b1;
    wr(fcg_pkg::OFS_PROT, 8'h00);
    background_debug_mode <= 1'b0;
    rd(fcg_pkg::OFS_PROT, 8'h00);
    seq(16'h8000, 16'h3333, fcg_pkg::CMD_MERASE, 1'b0);
    rd(fcg_pkg::OFS_STATUS, 8'hE0);
    wr(fcg_pkg::OFS_STATUS, 8'h20);
    rd(fcg_pkg::OFS_STATUS, 8'hC0);
    $display("test protect done");
  endtask

  // Stop entry kills the active command; reset mid-command aborts too
  task automatic t_stop();
    seq(16'h8000, 16'h4444, fcg_pkg::CMD_PROG, 1'b0);
    stop_mode <= 1'b1;
    #1 chk(16'(eng_abort), 16'h0001);
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    rd(fcg_pkg::OFS_STATUS, 8'hD0);
    wr(fcg_pkg::OFS_STATUS, 8'h10);
    seq(16'h8000, 16'h4444, fcg_pkg::CMD_PROG, 1'b0);
    do_reset();
    $display("test stop done");
  endtask

  // Secured source refusal, key access unsecure, lock on bad key
  task automatic t_secure();
    wr(fcg_pkg::OFS_CLKDIV, 8'h0A);
    nonsec_src <= 1'b1;
    seq(16'h8000, 16'h5555, fcg_pkg::CMD_PROG, 1'b0);
    chk(16'(st), 16'h0000);
    nonsec_src <= 1'b0;
    rd(fcg_pkg::OFS_STATUS, 8'hD0);
    wr(fcg_pkg::OFS_STATUS, 8'h10);
    wr(fcg_pkg::OFS_CONFIG, 8'h20);
    ard(16'hFFFF);
    for (int i = 0; i < 4; i++) awr(16'hFF00 + 16'(2 * i), keys[63 - 16 * i -: 16], 1'b0, 1'b0);
    wr(fcg_pkg::OFS_CONFIG, 8'h00);
    @(posedge ref_clk);
    #1 chk(16'(secured), 16'h0000);
    rd(fcg_pkg::OFS_SECURE, 8'h82);
    do_reset();
    rd(fcg_pkg::OFS_SECURE, 8'h80);
    rd(fcg_pkg::OFS_PROT, 8'hFF);
    background_debug_mode <= 1'b1;
    ssc <= 1'b1;
    wr(fcg_pkg::OFS_CONFIG, 8'h20);
    for (int i = 0; i < 4; i++) awr(16'hFF00 + 16'(2 * i), keys[63 - 16 * i -: 16], 1'b0, 1'b0);
    wr(fcg_pkg::OFS_CONFIG, 8'h00);
    background_debug_mode <= 1'b0;
    ssc <= 1'b0;
    @(posedge ref_clk);
    #1 chk(16'(secured), 16'h0001);
    wr(fcg_pkg::OFS_STATUS, 8'h10);
    wr(fcg_pkg::OFS_CONFIG, 8'h20);
    awr(16'hFF00, 16'h0000, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) awr(16'hFF00 + 16'(2 * i), keys[63 - 16 * i -: 16], 1'b0, 1'b0);
    wr(fcg_pkg::OFS_CONFIG, 8'h00);
    @(posedge ref_clk);
    #1 chk(16'(secured), 16'h0001);
    $display("test secure done");
  endtask

  initial begin
    t_prog();
    t_errors();
    t_protect();
    t_stop();
    t_secure();
    print_verdict();
  end
endmodule
`default_nettype wire
